// [hw/spc_map.svh]
// Port offsets, field positions, reset values and core clock frequency for speech playback control
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
// ----------------------------------------
// Port offsets, reset values, stop code and status bit
// ----------------------------------------
`define SPC_RATE_OFFSET 4'h5
`define SPC_ADDR_OFFSET 4'h6
`define SPC_RATE_RESET 4'h0
`define SPC_ADDR_RESET 4'h0
`define SPC_STOP_CODE 4'hF
`define SPC_ACT_BIT 3
// ----------------------------------------
// Timing
// ----------------------------------------
`define SPC_CLK_HZ 10000000
`endif

// [hw/spc_pkg.sv]
// Types for speech playback control
`default_nettype none
package spc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [3:0] wdata;
  } spc_port_req_type;
  typedef enum logic [1:0] {
    SPC_NIB_LOW,
    SPC_NIB_MID,
    SPC_NIB_HIGH
  } spc_nib_type;
endpackage
`default_nettype wire

// [hw/spc_speech_ctrl.sv]
// Speech playback control front end
`timescale 1ns/100ps
`default_nettype none
`include "spc_map.svh"
module spc_speech_ctrl #(
  parameter int ADDR_W = 12,
  parameter logic [ADDR_W-1:0] LAST_ADDR = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core port access
  input wire spc_pkg::spc_port_req_type port_req,
  output logic [3:0] port_rdata,
  // Playback outputs
  output logic playback_active_flag,
  output logic speech_end_irq,
  output logic sample_tick,
  output logic [ADDR_W-1:0] sample_addr
);
  // ----------------------------------------
  // Rate decode
  // ----------------------------------------
  // Cycles per sample at the core clock; truncated, so the 12K and 15K rates run slightly fast
  function automatic logic [11:0] rate_div(input logic [2:0] sel);
    begin
      case (sel)
        3'h1: rate_div = 12'(`SPC_CLK_HZ / 5000);
        3'h3: rate_div = 12'(`SPC_CLK_HZ / 8000);
        3'h4: rate_div = 12'(`SPC_CLK_HZ / 10000);
        3'h5: rate_div = 12'(`SPC_CLK_HZ / 12000);
        3'h6: rate_div = 12'(`SPC_CLK_HZ / 15000);
        3'h7: rate_div = 12'(`SPC_CLK_HZ / 20000);
        default: rate_div = 12'(`SPC_CLK_HZ / 4000);
      endcase
    end
  endfunction

  logic [3:0] rate_reg, rate_next;
  logic [3:0] addr_port_reg, addr_port_next;
  logic [3:0] nib0_reg, nib0_next, nib1_reg, nib1_next;
  spc_pkg::spc_nib_type nib_reg, nib_next;
  logic [1:0] stop_cnt_reg, stop_cnt_next;
  logic act_reg, act_next;
  logic irq_reg, irq_next;
  logic tick_reg, tick_next;
  logic [11:0] div_reg, div_next;
  logic [11:0] start_reg, start_next;
  logic [ADDR_W-1:0] ptr_reg, ptr_next;
  logic [3:0] rdata_reg, rdata_next;
  logic wr_addr, wr_rate;

  assign wr_addr = port_req.wr && port_req.addr == `SPC_ADDR_OFFSET;
  assign wr_rate = port_req.wr && port_req.addr == `SPC_RATE_OFFSET;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    rate_next = rate_reg;
    addr_port_next = addr_port_reg;
    nib0_next = nib0_reg;
    nib1_next = nib1_reg;
    nib_next = nib_reg;
    stop_cnt_next = stop_cnt_reg;
    act_next = act_reg;
    tick_next = 1'b0;
    div_next = div_reg;
    start_next = start_reg;
    ptr_next = ptr_reg;
    rdata_next = rdata_reg;
    if (wr_addr) begin
      addr_port_next = port_req.wdata;
      case (nib_reg)
        spc_pkg::SPC_NIB_LOW: begin
          nib0_next = port_req.wdata;
          nib_next = spc_pkg::SPC_NIB_MID;
        end
        spc_pkg::SPC_NIB_MID: begin
          nib1_next = port_req.wdata;
          nib_next = spc_pkg::SPC_NIB_HIGH;
        end
        spc_pkg::SPC_NIB_HIGH: begin
          start_next = {port_req.wdata, nib1_reg, nib0_reg};
          nib_next = spc_pkg::SPC_NIB_LOW;
        end
        default: nib_next = spc_pkg::SPC_NIB_LOW;
      endcase
      if (port_req.wdata == `SPC_STOP_CODE) begin
        stop_cnt_next = stop_cnt_reg + 2'h1;
      end else begin
        stop_cnt_next = 2'h0;
      end
      if (port_req.wdata == `SPC_STOP_CODE && stop_cnt_reg == 2'h2) begin
        act_next = 1'b0;
        stop_cnt_next = 2'h0;
        nib_next = spc_pkg::SPC_NIB_LOW;
      end
    end
    if (wr_rate) begin
      rate_next = port_req.wdata;
      act_next = 1'b1;
      ptr_next = ADDR_W'(start_reg);
      div_next = rate_div(port_req.wdata[2:0]);
      nib_next = spc_pkg::SPC_NIB_LOW;
    end else if (act_reg) begin
      if (div_reg <= 12'h001) begin
        div_next = rate_div(rate_reg[2:0]);
        tick_next = 1'b1;
        if (ptr_reg == LAST_ADDR) begin
          act_next = 1'b0;
        end else begin
          ptr_next = ptr_reg + 1'b1;
        end
      end else begin
        div_next = div_reg - 12'h001;
      end
    end
    irq_next = act_reg && !act_next;
    rdata_next = 4'h0;
    if (port_req.rd && port_req.addr == `SPC_ADDR_OFFSET) begin
      rdata_next[`SPC_ACT_BIT] = act_reg;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_reg <= `SPC_RATE_RESET;
      addr_port_reg <= `SPC_ADDR_RESET;
      nib0_reg <= 4'h0;
      nib1_reg <= 4'h0;
      nib_reg <= spc_pkg::SPC_NIB_LOW;
      stop_cnt_reg <= 2'h0;
      act_reg <= 1'b0;
      irq_reg <= 1'b0;
      tick_reg <= 1'b0;
      div_reg <= 12'h000;
      start_reg <= 12'h000;
      ptr_reg <= '0;
      rdata_reg <= 4'h0;
    end else begin
      rate_reg <= rate_next;
      addr_port_reg <= addr_port_next;
      nib0_reg <= nib0_next;
      nib1_reg <= nib1_next;
      nib_reg <= nib_next;
      stop_cnt_reg <= stop_cnt_next;
      act_reg <= act_next;
      irq_reg <= irq_next;
      tick_reg <= tick_next;
      div_reg <= div_next;
      start_reg <= start_next;
      ptr_reg <= ptr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign port_rdata = rdata_reg;
  assign playback_active_flag = act_reg;
  assign speech_end_irq = irq_reg;
  assign sample_tick = tick_reg;
  assign sample_addr = ptr_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_irq_on_fall;
    // Reset drops the flag without an interrupt
    @(posedge clk) disable iff (rst) $fell(act_reg) && !$past(rst) |-> irq_reg;
  endproperty
  a_irq_on_fall: assert property (p_irq_on_fall) else $error("irq missing on fall");

  property p_irq_cause;
    @(posedge clk) disable iff (rst) irq_reg |-> $past(act_reg) && !act_reg;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without fall");

  property p_rate_starts;
    @(posedge clk) disable iff (rst) wr_rate |=> act_reg;
  endproperty
  a_rate_starts: assert property (p_rate_starts) else $error("rate write no start");

  property p_stop_three;
    @(posedge clk) disable iff (rst)
      (wr_addr && port_req.wdata == 4'hF && !wr_rate) [*3] |=> !act_reg;
  endproperty
  a_stop_three: assert property (p_stop_three) else $error("stop not taken");

  property p_status_read;
    @(posedge clk) disable iff (rst)
      port_req.rd && port_req.addr == 4'h6 |=> port_rdata == {$past(act_reg), 3'h0};
  endproperty
  a_status_read: assert property (p_status_read) else $error("bad status read");

  property p_assemble;
    @(posedge clk) disable iff (rst)
      wr_addr && nib_reg == spc_pkg::SPC_NIB_HIGH
      |=> start_reg == {$past(port_req.wdata), $past(nib1_reg), $past(nib0_reg)};
  endproperty
  a_assemble: assert property (p_assemble) else $error("address not assembled");

  property p_rate_8k;
    @(posedge clk) disable iff (rst)
      wr_rate && port_req.wdata[2:0] == 3'h3 |=> div_reg == 12'h4E2;
  endproperty
  a_rate_8k: assert property (p_rate_8k) else $error("8K divide wrong");

  property p_rate_20k;
    @(posedge clk) disable iff (rst)
      wr_rate && port_req.wdata[2:0] == 3'h7 |=> div_reg == 12'h1F4;
  endproperty
  a_rate_20k: assert property (p_rate_20k) else $error("20K divide wrong");

  property p_ptr_end;
    @(posedge clk) disable iff (rst)
      act_reg && !wr_rate && !wr_addr && div_reg <= 12'h001 && ptr_reg == LAST_ADDR |=> !act_reg;
  endproperty
  a_ptr_end: assert property (p_ptr_end) else $error("no end at last sample");

  property p_reset_clear;
    @(posedge clk) rst |=> rate_reg == 4'h0 && addr_port_reg == 4'h0 && !act_reg;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset not cleared");
endmodule
`default_nettype wire

// [tb/spc_speech_ctrl_tb_top.sv]
// Self-checking bench for the speech playback control front end
`timescale 1ns/100ps
`default_nettype none
module spc_speech_ctrl_tb_top;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  // Small end address keeps end-of-speech runs short
  localparam logic [11:0] LAST_A = 12'h123;
  logic clk = 1'b0;
  logic rst = 1'b1;
  spc_pkg::spc_port_req_type req;
  logic [3:0] rdata;
  logic act;
  logic irq;
  logic tick;
  logic [11:0] saddr;
  logic [3:0] d;
  int err_total = 0;
  int comparisons = 0;
  int n;
  // Cycles per sample at 10 MHz for select codes 0 to 7
  int divs [8] = '{2500, 2000, 2500, 1250, 1000, 833, 666, 500};
  spc_speech_ctrl #(.ADDR_W(12), .LAST_ADDR(LAST_A)) uut (
    .clk(clk), .rst(rst), .port_req(req), .port_rdata(rdata),
    .playback_active_flag(act), .speech_end_irq(irq),
    .sample_tick(tick), .sample_addr(saddr)
  );
  always #50 clk = ~clk;
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until the edge that takes it; no release in between
  task automatic put(input logic [3:0] a, input logic [3:0] v);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    #10;
  endtask
  task automatic idle;
    req = '0;
    @(posedge clk);
    #10;
  endtask
  task automatic rd(input logic [3:0] a, output logic [3:0] v);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 4'h0};
    @(posedge clk);
    #10;
    v = rdata;
  endtask
  task automatic play(input logic [11:0] a, input logic [3:0] r);
    put(4'h6, a[3:0]);
    put(4'h6, a[7:4]);
    put(4'h6, a[11:8]);
    put(4'h5, r);
    chk_bit(act, 1'b1);
    chk_addr(saddr, a);
    idle;
  endtask
  task automatic stop;
    put(4'h6, 4'hF);
    put(4'h6, 4'hF);
    put(4'h6, 4'hF);
    chk_bit(act, 1'b0);
    chk_bit(irq, 1'b1);
    idle;
    chk_bit(irq, 1'b0);
  endtask
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #10;
      c++;
    end while (tick !== 1'b1 && c < 3000);
  endtask
  task automatic results;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    req = '0;
    repeat (10) @(posedge clk);
    #10 rst = 1'b0;
    chk_bit(act, 1'b0);
    rd(4'h6, d);
    chk_nib(d, 4'h0);
    idle;
    // Stray write to another port must not disturb nibble assembly
    put(4'h6, 4'h0);
    put(4'h7, 4'h9);
    put(4'h6, 4'h4);
    put(4'h6, 4'h0);
    put(4'h5, 4'h3);
    chk_bit(act, 1'b1);
    chk_addr(saddr, 12'h040);
    rd(4'h6, d);
    chk_nib(d, 4'h8);
    rd(4'h5, d);
    chk_nib(d, 4'h0);
    idle;
    stop;
    // Second tick spans one full sample period
    for (int i = 0; i < 8; i++) begin
      play(12'h100, i[3:0]);
      wait_tick(n);
      wait_tick(n);
      chk_cnt(n, divs[i]);
      chk_addr(saddr, 12'h102);
      stop;
    end
    // Two samples at 20K; the count starts one edge after the start
    play(LAST_A - 12'h001, 4'h7);
    n = 0;
    while (act === 1'b1 && n < 5000) begin
      @(posedge clk);
      #10;
      n++;
    end
    chk_bit(act, 1'b0);
    chk_bit(irq, 1'b1);
    chk_cnt(n, 2 * 500 - 1);
    // All-ones run while silent gives no interrupt
    put(4'h6, 4'hF);
    put(4'h6, 4'hF);
    put(4'h6, 4'hF);
    chk_bit(act, 1'b0);
    chk_bit(irq, 1'b0);
    idle;
    // Another nibble breaks the all-ones run
    play(12'h050, 4'h3);
    put(4'h6, 4'hF);
    put(4'h6, 4'hF);
    put(4'h6, 4'h0);
    chk_bit(act, 1'b1);
    chk_addr(saddr, 12'h050);
    stop;
    // Reset in mid playback clears flag and status
    play(12'h050, 4'h3);
    rst = 1'b1;
    @(posedge clk);
    #10;
    chk_bit(act, 1'b0);
    chk_bit(irq, 1'b0);
    chk_addr(saddr, 12'h000);
    rst = 1'b0;
    rd(4'h6, d);
    chk_nib(d, 4'h0);
    idle;
    results;
  end
  initial begin
    #5000000;
    err_total++;
    results;
  end
endmodule
`default_nettype wire
